// [rtl/single_wire_bus_master.sv]
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
// Behaviour
// - Reset pulse 480us or more, then presence check
// - Request bit starts reset, clears itself after
// - Presence outcome latched into presence status
// - Write-zero slot 117us, low 100us
// - Write-zero bit starts slot, self-clears
// - Write-one and read share timing
// - Write-one/read bit starts slot, self-clears
// - Read slot end loads sampled bit
// - Opening low pulse 5us, within 1-15us
// - Read sample at 13us, before 15us
// - Divide clock to about 1MHz tick
// - Divide ratio is nearest integer MHz
module single_wire_bus_master (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  // APB slave
  input  wire swire_pkg::apb_req_t  apb_i,
  output      swire_pkg::apb_rsp_t  apb_o,
  // Open-drain line
  input  wire logic                 line_i,
  output      logic                 line_o,
  output      logic                 line_oe_o,
  // Interrupt
  output      logic                 irq_o
);
  import swire_pkg::*;

  localparam logic [DIV_W-1:0] DIV_LAST   = DIV_W'(TICK_DIV - 1);
  localparam logic [US_W-1:0]  RLOW_LAST  = US_W'(RESET_LOW_US - 1);
  localparam logic [US_W-1:0]  RHIGH_LAST = US_W'(RESET_HIGH_US - 1);
  localparam logic [US_W-1:0]  PRES_AT    = US_W'(PRES_SAMPLE_US);
  localparam logic [US_W-1:0]  ZLOW_END   = US_W'(ZERO_LOW_US);
  localparam logic [US_W-1:0]  ZSLOT_LAST = US_W'(ZERO_SLOT_US - 1);
  localparam logic [US_W-1:0]  SLOW_END   = US_W'(SLOT_LOW_US);
  localparam logic [US_W-1:0]  RSAMP_AT   = US_W'(READ_SAMPLE_US);
  localparam logic [US_W-1:0]  BSLOT_LAST = US_W'(BIT_SLOT_US - 1);

  swm_state_t s_reg;
  swm_state_t s_next;
  logic       tick;
  logic       wr_en;
  logic       rd_en;
  logic       bus_idle;
  logic       pres_seen_reg;
  logic       samp_reg;
  logic       pres_seen_next;
  logic       samp_next;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  assign tick     = (s_reg.div == DIV_LAST);
  assign wr_en    = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign rd_en    = apb_i.psel && !apb_i.penable && !apb_i.pwrite;
  assign bus_idle = (s_reg.state == ST_IDLE);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next         = s_reg;
    pres_seen_next = pres_seen_reg;
    samp_next      = samp_reg;
    s_next.div     = tick ? '0 : s_reg.div + 1'b1;
    if (tick && !bus_idle) begin
      s_next.us = s_reg.us + 1'b1;
    end

    case (s_reg.state)
      ST_IDLE: begin
        s_next.line_oe = 1'b0;
        s_next.us      = '0;
        if (tick) begin
          if (s_reg.reset_presence_request) begin
            s_next.state   = ST_RLOW;
            s_next.line_oe = 1'b1;
          end else if (s_reg.write_zero_go) begin
            s_next.state   = ST_ZERO;
            s_next.line_oe = 1'b1;
          end else if (s_reg.write_one_read_go) begin
            s_next.state   = ST_BIT;
            s_next.line_oe = 1'b1;
          end
        end
      end
      ST_RLOW: begin
        if (tick && s_reg.us == RLOW_LAST) begin
          s_next.state   = ST_RHIGH;
          s_next.line_oe = 1'b0;
          s_next.us      = '0;
          pres_seen_next = 1'b0;
        end
      end
      ST_RHIGH: begin
        if (tick && s_reg.us == PRES_AT - 1'b1 && !line_i) begin
          pres_seen_next = 1'b1;
        end
        if (tick && s_reg.us == RHIGH_LAST) begin
          s_next.state                  = ST_IDLE;
          s_next.presence_status        = pres_seen_reg;
          s_next.reset_presence_request = 1'b0;
          s_next.irq_stat               = s_reg.irq_stat | IRQ_RESET_DONE;
        end
      end
      ST_ZERO: begin
        if (tick && s_reg.us == ZLOW_END - 1'b1) begin
          s_next.line_oe = 1'b0;
        end
        if (tick && s_reg.us == ZSLOT_LAST) begin
          s_next.state         = ST_IDLE;
          s_next.write_zero_go = 1'b0;
          s_next.irq_stat      = s_reg.irq_stat | IRQ_ZERO_DONE;
        end
      end
      ST_BIT: begin
        if (tick && s_reg.us == SLOW_END - 1'b1) begin
          s_next.line_oe = 1'b0;
        end
        if (tick && s_reg.us == RSAMP_AT - 1'b1) begin
          samp_next = line_i;
        end
        if (tick && s_reg.us == BSLOT_LAST) begin
          s_next.state             = ST_IDLE;
          s_next.read_bit_status   = samp_reg;
          s_next.write_one_read_go = 1'b0;
          s_next.irq_stat          = s_reg.irq_stat | IRQ_BIT_DONE;
        end
      end
      default: begin
        s_next.state   = ST_IDLE;
        s_next.line_oe = 1'b0;
      end
    endcase

    // Register writes; a go bit is only taken while idle
    if (wr_en) begin
      case (apb_i.paddr)
        CTRL_OFS: begin
          if (bus_idle && !s_reg.reset_presence_request && !s_reg.write_zero_go
              && !s_reg.write_one_read_go) begin
            s_next.reset_presence_request = apb_i.pwdata[RPR_BIT];
            s_next.write_zero_go          = apb_i.pwdata[W0_BIT];
            s_next.write_one_read_go      = apb_i.pwdata[W1R_BIT];
          end
        end
        IRQ_STAT_OFS: begin
          s_next.irq_stat = s_next.irq_stat & ~(apb_i.pwdata[IRQ_W-1:0] & ~(s_next.irq_stat ^ s_reg.irq_stat));
        end
        IRQ_MASK_OFS: begin
          s_next.irq_mask = apb_i.pwdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Read data captured in setup phase
    if (rd_en) begin
      case (apb_i.paddr)
        CTRL_OFS:     s_next.prdata = {29'h0, s_reg.write_one_read_go, s_reg.write_zero_go,
                                       s_reg.reset_presence_request};
        STAT_OFS:     s_next.prdata = {29'h0, !bus_idle, s_reg.read_bit_status, s_reg.presence_status};
        IRQ_STAT_OFS: s_next.prdata = {29'h0, s_reg.irq_stat};
        IRQ_MASK_OFS: s_next.prdata = {29'h0, s_reg.irq_mask};
        default:      s_next.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_reg.state                  <= ST_IDLE;
      s_reg.div                    <= '0;
      s_reg.us                     <= '0;
      s_reg.reset_presence_request <= 1'b0;
      s_reg.write_zero_go          <= 1'b0;
      s_reg.write_one_read_go      <= 1'b0;
      s_reg.presence_status        <= 1'b0;
      s_reg.read_bit_status        <= 1'b0;
      s_reg.line_oe                <= 1'b0;
      s_reg.irq_stat               <= '0;
      s_reg.irq_mask               <= '0;
      s_reg.prdata                 <= 32'h0000_0000;
      pres_seen_reg                <= 1'b0;
      samp_reg                     <= 1'b0;
    end else begin
      s_reg         <= s_next;
      pres_seen_reg <= pres_seen_next;
      samp_reg      <= samp_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign line_o        = 1'b0;
  assign line_oe_o     = s_reg.line_oe;
  assign irq_o         = |(s_reg.irq_stat & s_reg.irq_mask);
  assign apb_o.pready  = 1'b1;
  assign apb_o.pslverr = 1'b0;
  assign apb_o.prdata  = s_reg.prdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rst_start;
    bus_idle && tick && s_reg.reset_presence_request;
  endsequence

  property p_reset_low;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(s_reg.state == ST_RLOW) |-> (s_reg.line_oe && s_reg.state == ST_RLOW) [*8];
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("reset pulse cut short");

  property p_reset_len;
    @(posedge clk_i) disable iff (!rstn_i)
      $fell(s_reg.state == ST_RLOW) |-> $past(s_reg.us) == RLOW_LAST;
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset pulse length wrong");

  property p_rpr_start;
    @(posedge clk_i) disable iff (!rstn_i)
      s_rst_start |=> s_reg.state == ST_RLOW && line_oe_o;
  endproperty
  a_rpr_start: assert property (p_rpr_start) else $error("reset request not launched");

  property p_rpr_clear;
    @(posedge clk_i) disable iff (!rstn_i)
      $fell(s_reg.state == ST_RHIGH) |-> !s_reg.reset_presence_request;
  endproperty
  a_rpr_clear: assert property (p_rpr_clear) else $error("reset request not cleared");

  property p_presence;
    @(posedge clk_i) disable iff (!rstn_i)
      $fell(s_reg.state == ST_RHIGH) |-> s_reg.presence_status == $past(pres_seen_reg);
  endproperty
  a_presence: assert property (p_presence) else $error("presence not latched");

  property p_zero_low;
    @(posedge clk_i) disable iff (!rstn_i)
      $fell(s_reg.line_oe) && s_reg.state == ST_ZERO |-> s_reg.us == ZLOW_END;
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("write-zero low time wrong");

  property p_zero_clear;
    @(posedge clk_i) disable iff (!rstn_i)
      $fell(s_reg.state == ST_ZERO) |-> !s_reg.write_zero_go && $past(s_reg.us) == ZSLOT_LAST;
  endproperty
  a_zero_clear: assert property (p_zero_clear) else $error("write-zero slot end wrong");

  property p_slot_low;
    @(posedge clk_i) disable iff (!rstn_i)
      $fell(s_reg.line_oe) && s_reg.state == ST_BIT |-> s_reg.us == SLOW_END;
  endproperty
  a_slot_low: assert property (p_slot_low) else $error("slot low pulse wrong");

  property p_bit_end;
    @(posedge clk_i) disable iff (!rstn_i)
      $fell(s_reg.state == ST_BIT) |-> !s_reg.write_one_read_go && s_reg.read_bit_status == $past(samp_reg);
  endproperty
  a_bit_end: assert property (p_bit_end) else $error("read result or go clear wrong");

  property p_idle_release;
    @(posedge clk_i) disable iff (!rstn_i)
      bus_idle |-> !line_oe_o;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("line driven while idle");

endmodule

// [rtl/swire_pkg.sv]
package swire_pkg;

  // ----------------------------------------
  // Clock and time base
  // ----------------------------------------
  localparam int unsigned CLK_KHZ         = 40000;
  localparam int unsigned TICK_KHZ        = 1000;
  localparam int unsigned TICK_DIV        = (CLK_KHZ + TICK_KHZ / 2) / TICK_KHZ;
  localparam int unsigned DIV_W           = 6;

  // ----------------------------------------
  // Slot timing in microseconds (one tick each)
  // ----------------------------------------
  localparam int unsigned RESET_LOW_US    = 511;
  localparam int unsigned RESET_HIGH_US   = 512;
  localparam int unsigned PRES_SAMPLE_US  = 68;
  localparam int unsigned ZERO_LOW_US     = 100;
  localparam int unsigned ZERO_SLOT_US    = 117;
  localparam int unsigned SLOT_LOW_US     = 5;
  localparam int unsigned READ_SAMPLE_US  = 13;
  localparam int unsigned BIT_SLOT_US     = 117;
  localparam int unsigned US_W            = 11;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] CTRL_OFS        = 12'h000;
  localparam logic [11:0] STAT_OFS        = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFS    = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS    = 12'h00C;
  localparam int unsigned RPR_BIT         = 0;
  localparam int unsigned W0_BIT          = 1;
  localparam int unsigned W1R_BIT         = 2;
  localparam int unsigned PST_BIT         = 0;
  localparam int unsigned RDB_BIT         = 1;
  localparam int unsigned BUSY_BIT        = 2;
  localparam int unsigned IRQ_W           = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET_DONE = 3'h1;
  localparam logic [IRQ_W-1:0] IRQ_ZERO_DONE  = 3'h2;
  localparam logic [IRQ_W-1:0] IRQ_BIT_DONE   = 3'h4;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RLOW  = 5'b00010,
    ST_RHIGH = 5'b00100,
    ST_ZERO  = 5'b01000,
    ST_BIT   = 5'b10000
  } seq_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    seq_state_t       state;
    logic [DIV_W-1:0] div;
    logic [US_W-1:0]  us;
    logic             reset_presence_request;
    logic             write_zero_go;
    logic             write_one_read_go;
    logic             presence_status;
    logic             read_bit_status;
    logic             line_oe;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0]      prdata;
  } swm_state_t;

endpackage

// [bench/swire_slave_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Slave device on the shared line
// ----------------------------------------
module swire_slave_model (
  // Line side
  input  wire logic line_i,
  output      logic pull_o,
  // Bench side
  input  wire logic present_i,
  input  wire logic bit_i,
  output      logic seen_o
);
  logic    pres_pull;
  logic    rd_pull;
  logic    long_low;
  realtime t_fall;

  initial begin
    pres_pull = 1'b0;
    rd_pull = 1'b0;
    seen_o = 1'b1;
    t_fall = 0;
  end

  assign pull_o = pres_pull | rd_pull;

  always @(negedge line_i) begin
    if (!pull_o) begin
      t_fall = $realtime;
      #7000 rd_pull = present_i & ~bit_i;
      #23000 seen_o = line_i;
      #30000 rd_pull = 1'b0;
    end
  end

  always @(posedge line_i) begin
    long_low = ($realtime - t_fall >= 480000);
    t_fall = $realtime;
    if (long_low && present_i) begin
      #30000 pres_pull = 1'b1;
      #100000 pres_pull = 1'b0;
    end
  end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import swire_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int DIV = 40;
  logic        clk_i;
  logic        rstn_i;
  apb_req_t    apb_i;
  apb_rsp_t    apb_o;
  logic        line_o;
  logic        line_oe_o;
  logic        irq_o;
  logic        line;
  logic        pull;
  logic        seen;
  logic        present;
  logic        bit_v;
  logic [31:0] rnd;
  logic [31:0] q;
  int          n_fail;
  int          samples_checked;
  int          run = 0;
  int          low_len = 0;

  assign line = (line_oe_o ? line_o : 1'b1) & ~pull;

  single_wire_bus_master i_single_wire_bus_master (
    .clk_i(clk_i), .rstn_i(rstn_i), .apb_i(apb_i), .apb_o(apb_o),
    .line_i(line), .line_o(line_o), .line_oe_o(line_oe_o), .irq_o(irq_o));
  swire_slave_model i_swire_slave_model (
    .line_i(line), .pull_o(pull), .present_i(present), .bit_i(bit_v), .seen_o(seen));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Length of each low drive in clocks
  always @(posedge clk_i) begin
    if (line_oe_o) begin
      run <= run + 1;
    end else if (run != 0) begin
      low_len <= run;
      run <= 0;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    do @(posedge clk_i); while (apb_o.pready !== 1'b1);
    q = apb_o.prdata;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic run_seq(input logic [2:0] go, input int exp_low);
    apb(1'b1, CTRL_OFS, {29'h0, go});
    apb(1'b1, CTRL_OFS, 32'h2);
    repeat (DIV) @(posedge clk_i);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("busy", 1, q[2]);
    do apb(1'b0, CTRL_OFS, 32'h0); while (q[2:0] !== 3'h0);
    chk("low time", exp_low, low_len);
    chk("irq raised", 1, irq_o);
    apb(1'b1, IRQ_MASK_OFS, 32'h0);
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    chk("irq masked", {go, 1'b0}, {q[2:0], irq_o});
    apb(1'b1, IRQ_STAT_OFS, {29'h0, go});
    apb(1'b1, IRQ_MASK_OFS, 32'h7);
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    chk("irq cleared", 0, {q[2:0], irq_o});
    $display("sequence %h done", go);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    apb_i = '0;
    rstn_i = 1'b0;
    present = 1'b0;
    bit_v = 1'b1;
    rnd = 32'd86;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    rnd = xs(rnd);
    apb(1'b1, 12'h010, rnd);
    for (int a = 0; a < 20; a += 4) begin
      apb(1'b0, a[11:0], 32'h0);
      chk("reset value", 0, q);
    end
    chk("line idle", 0, line_oe_o);
    apb(1'b1, IRQ_MASK_OFS, {rnd[31:3], 3'h7});
    apb(1'b0, IRQ_MASK_OFS, 32'h0);
    chk("mask", 32'h7, q);
    $display("registers done");
    run_seq(3'h1, RESET_LOW_US * DIV);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("presence", 0, q[0]);
    present <= 1'b1;
    run_seq(3'h1, RESET_LOW_US * DIV);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("presence", 1, q[0]);
    for (int i = 0; i < 2; i++) begin
      bit_v <= (i == 0);
      run_seq(3'h4, SLOT_LOW_US * DIV);
      apb(1'b0, STAT_OFS, 32'h0);
      chk("read bit", i == 0, q[1]);
      chk("slave saw", i == 0, seen);
      if (i == 0) begin
        run_seq(3'h2, ZERO_LOW_US * DIV);
        chk("slave saw", 0, seen);
      end
    end
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end
endmodule
